/* File: hdl/cfg_serial_port.v */
// serial configuration port: oversampled shifter producing register strobes
`timescale 1ns/10ps
`include "converter_cfg_pages_regs.vh"

module cfg_serial_port (
  input wire clk_i,
  input wire rst_i,
  input wire sen_n_i,
  input wire sclk_i,
  input wire sdin_i,
  input wire [7:0] rdata_i,
  output reg sdout_o,
  output reg sdout_oe_n_o,
  output reg wr_o,
  output reg [14:0] addr_o,
  output reg [7:0] wdata_o
);

  reg [1:0] sen_sync;
  reg [1:0] sclk_sync;
  reg [1:0] sdin_sync;
  reg sclk_prev;
  reg [4:0] bit_cnt;
  reg [22:0] shift_in;
  reg is_read;
  reg load_pend;
  reg [7:0] shift_out;
  wire rise;
  wire fall;

  // edges are taken from the second stage only
  assign rise = sclk_sync[1] & ~sclk_prev;
  assign fall = ~sclk_sync[1] & sclk_prev;

  always @(posedge clk_i) begin
    if (rst_i) begin
      sen_sync <= 2'h3;
      sclk_sync <= 2'h0;
      sdin_sync <= 2'h0;
      sclk_prev <= 1'b0;
    end else begin
      sen_sync <= {sen_sync[0], sen_n_i};
      sclk_sync <= {sclk_sync[0], sclk_i};
      sdin_sync <= {sdin_sync[0], sdin_i};
      sclk_prev <= sclk_sync[1];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      bit_cnt <= 5'h00;
      shift_in <= 23'h000000;
      is_read <= 1'b0;
      load_pend <= 1'b0;
      shift_out <= 8'h00;
      sdout_o <= 1'b0;
      sdout_oe_n_o <= 1'b1;
      wr_o <= 1'b0;
      addr_o <= 15'h0000;
      wdata_o <= 8'h00;
    end else begin
      wr_o <= 1'b0;
      load_pend <= 1'b0;
      if (sen_sync[1]) begin
        // a frame cut short by a rising enable is dropped without a write
        bit_cnt <= 5'h00;
        is_read <= 1'b0;
        sdout_oe_n_o <= 1'b1;
      end else begin
        if (rise && bit_cnt != `CFG_FRAME_BITS) begin
          shift_in <= {shift_in[21:0], sdin_sync[1]};
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == `CFG_HEADER_BITS - 5'h01) begin
            addr_o <= {shift_in[13:0], sdin_sync[1]};
            is_read <= shift_in[14];
            load_pend <= 1'b1;
          end
          if (bit_cnt == `CFG_FRAME_BITS - 5'h01 && !is_read) begin
            wr_o <= 1'b1;
            wdata_o <= {shift_in[6:0], sdin_sync[1]};
          end
        end
        if (load_pend && is_read) begin
          shift_out <= rdata_i;
        end
        if (fall && is_read && bit_cnt >= `CFG_HEADER_BITS) begin
          if (bit_cnt == `CFG_FRAME_BITS) begin
            sdout_oe_n_o <= 1'b1;
          end else begin
            sdout_o <= shift_out[7];
            shift_out <= {shift_out[6:0], 1'b0};
            sdout_oe_n_o <= 1'b0;
          end
        end
      end
    end
  end

endmodule

/* File: hdl/converter_cfg_pages.v */
// configuration register bank for the digital-top and analog pages
`timescale 1ns/10ps
`include "converter_cfg_pages_regs.vh"

module converter_cfg_pages (
  input wire CLK_I,
  input wire RST_I,
  input wire SEN_N_I,
  input wire SCLK_I,
  input wire SDIN_I,
  input wire SYSREF_I,
  input wire SLEEP_PIN_I,
  output wire SDOUT_O,
  output wire SDOUT_OE_N_O,
  output reg SYSREF_O,
  output wire PAIR_CD_AVG_OUTPUT_EN_O,
  output wire PAIR_CD_FIXED_ONE_BIT_O,
  output wire [3:0] PAIR_AB_DOWNCONV_SEL_O,
  output wire [3:0] PAIR_CD_DOWNCONV_SEL_O,
  output reg PAIR_AB_MODE_VALID_O,
  output reg PAIR_CD_MODE_VALID_O,
  output reg TRIM_LOAD_O,
  output wire TRIM_LOAD_ENABLE_O,
  output wire TRIM_RATE_SELECT_O,
  output wire [2:0] OUTPUT_SWING_CODE_O,
  output reg [9:0] OUTPUT_SWING_MV_O,
  output wire [5:0] LANE_A_DEEMPH_CODE_O,
  output wire [5:0] LANE_B_DEEMPH_CODE_O,
  output wire [5:0] LANE_C_DEEMPH_CODE_O,
  output wire [5:0] LANE_D_DEEMPH_CODE_O,
  output reg [3:0] DEEMPH_LEGAL_O,
  output wire SYSREF_BUFFER_OFF_O,
  output wire CHAN_A_OFF_O,
  output wire CHAN_B_OFF_O,
  output wire CHAN_C_OFF_O,
  output wire CHAN_D_OFF_O,
  output wire SYNC_AB_BUFFER_OFF_O,
  output wire SYNC_CD_BUFFER_OFF_O,
  output reg GLOBAL_SLEEP_O,
  output reg QUICK_SLEEP_O,
  output wire DIGITAL_PAGE_SELECT_O,
  output wire ANALOG_PAGE_SELECT_O
);

  localparam N = `CFG_REG_COUNT;

  wire wr;
  wire [14:0] addr;
  wire [7:0] wdata;
  wire [7:0] rdata;
  wire [5:0] lookup;
  wire hit;
  wire [4:0] idx;
  wire page_open;
  wire [8*N-1:0] bank;
  reg [1:0] sysref_sync;
  reg [1:0] sleep_sync;

  // {hit, index} for a full address; upper address bits must be zero
  function [5:0] reg_lookup;
    input [14:0] a;
    begin
      case (a)
        `OFS_DIGITAL_PAGE: reg_lookup = {1'b1, `IDX_DIGITAL_PAGE};
        `OFS_ANALOG_PAGE: reg_lookup = {1'b1, `IDX_ANALOG_PAGE};
        `OFS_TRIM_RATE: reg_lookup = {1'b1, `IDX_TRIM_RATE};
        `OFS_TRIM_LOAD_ENABLE: reg_lookup = {1'b1, `IDX_TRIM_LOAD_ENABLE};
        `OFS_PAIR_CD_INTERLEAVE: reg_lookup = {1'b1, `IDX_PAIR_CD_INTERLEAVE};
        `OFS_PAIR_AB_DDC: reg_lookup = {1'b1, `IDX_PAIR_AB_DDC};
        `OFS_PAIR_CD_DDC: reg_lookup = {1'b1, `IDX_PAIR_CD_DDC};
        `OFS_TRIM_LOAD_CMD: reg_lookup = {1'b1, `IDX_TRIM_LOAD_CMD};
        `OFS_SYSREF_MASK: reg_lookup = {1'b1, `IDX_SYSREF_MASK};
        `OFS_OUTPUT_SWING: reg_lookup = {1'b1, `IDX_OUTPUT_SWING};
        `OFS_DEEMPH_AB_HI: reg_lookup = {1'b1, `IDX_DEEMPH_AB_HI};
        `OFS_DEEMPH_B_LO: reg_lookup = {1'b1, `IDX_DEEMPH_B_LO};
        `OFS_DEEMPH_CD_HI: reg_lookup = {1'b1, `IDX_DEEMPH_CD_HI};
        `OFS_DEEMPH_D_LO: reg_lookup = {1'b1, `IDX_DEEMPH_D_LO};
        `OFS_SYSREF_BUFFER: reg_lookup = {1'b1, `IDX_SYSREF_BUFFER};
        `OFS_CHANNEL_POWER: reg_lookup = {1'b1, `IDX_CHANNEL_POWER};
        `OFS_GLOBAL_POWER: reg_lookup = {1'b1, `IDX_GLOBAL_POWER};
        `OFS_POWER_PIN_MODE: reg_lookup = {1'b1, `IDX_POWER_PIN_MODE};
        `OFS_SYNC_CD_BUFFER: reg_lookup = {1'b1, `IDX_SYNC_CD_BUFFER};
        default: reg_lookup = 6'h00;
      endcase
    end
  endfunction

  // only the defined field positions hold state
  function [7:0] reg_mask;
    input [4:0] i;
    begin
      case (i)
        `IDX_DIGITAL_PAGE: reg_mask = `MSK_DIGITAL_PAGE;
        `IDX_ANALOG_PAGE: reg_mask = `MSK_ANALOG_PAGE;
        `IDX_TRIM_RATE: reg_mask = `MSK_TRIM_RATE;
        `IDX_TRIM_LOAD_ENABLE: reg_mask = `MSK_TRIM_LOAD_ENABLE;
        `IDX_PAIR_CD_INTERLEAVE: reg_mask = `MSK_PAIR_CD_INTERLEAVE;
        `IDX_PAIR_AB_DDC: reg_mask = `MSK_PAIR_AB_DDC;
        `IDX_PAIR_CD_DDC: reg_mask = `MSK_PAIR_CD_DDC;
        `IDX_TRIM_LOAD_CMD: reg_mask = `MSK_TRIM_LOAD_CMD;
        `IDX_SYSREF_MASK: reg_mask = `MSK_SYSREF_MASK;
        `IDX_OUTPUT_SWING: reg_mask = `MSK_OUTPUT_SWING;
        `IDX_DEEMPH_AB_HI: reg_mask = `MSK_DEEMPH_HI;
        `IDX_DEEMPH_B_LO: reg_mask = `MSK_DEEMPH_LO;
        `IDX_DEEMPH_CD_HI: reg_mask = `MSK_DEEMPH_HI;
        `IDX_DEEMPH_D_LO: reg_mask = `MSK_DEEMPH_LO;
        `IDX_SYSREF_BUFFER: reg_mask = `MSK_SYSREF_BUFFER;
        `IDX_CHANNEL_POWER: reg_mask = `MSK_CHANNEL_POWER;
        `IDX_GLOBAL_POWER: reg_mask = `MSK_GLOBAL_POWER;
        `IDX_POWER_PIN_MODE: reg_mask = `MSK_POWER_PIN_MODE;
        `IDX_SYNC_CD_BUFFER: reg_mask = `MSK_SYNC_CD_BUFFER;
        default: reg_mask = 8'h00;
      endcase
    end
  endfunction

  // a mode code with a defined downconversion mode
  function mode_defined;
    input [3:0] code;
    begin
      mode_defined = (code <= 4'h8) && (code != 4'h5);
    end
  endfunction

  // de-emphasis codes with a defined attenuation step
  function deemph_defined;
    input [5:0] code;
    begin
      case (code)
        6'h00, 6'h01, 6'h03, 6'h07, 6'h0F, 6'h1F, 6'h3F: deemph_defined = 1'b1;
        default: deemph_defined = 1'b0;
      endcase
    end
  endfunction

  // nominal swing in mVpp; the upper four codes are the louder ones
  function [9:0] swing_mv;
    input [2:0] code;
    begin
      case (code)
        3'h0: swing_mv = 10'h35C;
        3'h1: swing_mv = 10'h32A;
        3'h2: swing_mv = 10'h302;
        3'h3: swing_mv = 10'h2E9;
        3'h4: swing_mv = 10'h3C0;
        3'h5: swing_mv = 10'h3A2;
        3'h6: swing_mv = 10'h389;
        default: swing_mv = 10'h370;
      endcase
    end
  endfunction

  cfg_serial_port port (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .sen_n_i(SEN_N_I),
    .sclk_i(SCLK_I),
    .sdin_i(SDIN_I),
    .rdata_i(rdata),
    .sdout_o(SDOUT_O),
    .sdout_oe_n_o(SDOUT_OE_N_O),
    .wr_o(wr),
    .addr_o(addr),
    .wdata_o(wdata)
  );

  assign lookup = reg_lookup(addr);
  assign hit = lookup[5];
  assign idx = lookup[4:0];
  assign DIGITAL_PAGE_SELECT_O = bank[8*`IDX_DIGITAL_PAGE + `BIT_PAGE_SELECT];
  assign ANALOG_PAGE_SELECT_O = bank[8*`IDX_ANALOG_PAGE + `BIT_PAGE_SELECT];

  // page selects themselves are always reachable; closed pages neither store nor answer
  assign page_open = (idx <= `IDX_ANALOG_PAGE) ||
                     ((idx <= `IDX_LAST_DIGITAL) && DIGITAL_PAGE_SELECT_O) ||
                     ((idx > `IDX_LAST_DIGITAL) && ANALOG_PAGE_SELECT_O);

  // unmapped or closed addresses read zero
  assign rdata = (hit && page_open) ? bank[{idx, 3'h0} +: 8] : 8'h00;

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : store
      // the genvar is 32 bits wide; the index is cut to the decoder's width on purpose
      localparam [4:0] SLOT = g;
      reg [7:0] value;
      always @(posedge CLK_I) begin
        if (RST_I) begin
          value <= `CFG_RESET_VALUE;
        end else if (wr && hit && page_open && idx == SLOT) begin
          value <= wdata & reg_mask(SLOT);
        end
      end
      assign bank[8*g +: 8] = value;
    end
  endgenerate

  assign PAIR_CD_AVG_OUTPUT_EN_O = bank[8*`IDX_PAIR_CD_INTERLEAVE + `BIT_CD_AVG_OUTPUT];
  assign PAIR_CD_FIXED_ONE_BIT_O = bank[8*`IDX_PAIR_CD_INTERLEAVE + `BIT_CD_FIXED_ONE];
  assign PAIR_AB_DOWNCONV_SEL_O = bank[8*`IDX_PAIR_AB_DDC +: 4];
  assign PAIR_CD_DOWNCONV_SEL_O = bank[8*`IDX_PAIR_CD_DDC +: 4];
  assign TRIM_LOAD_ENABLE_O = bank[8*`IDX_TRIM_LOAD_ENABLE + `BIT_TRIM_LOAD_ENABLE];
  assign TRIM_RATE_SELECT_O = bank[8*`IDX_TRIM_RATE + `BIT_TRIM_RATE];
  assign OUTPUT_SWING_CODE_O = bank[8*`IDX_OUTPUT_SWING + `BIT_SWING_LSB +: 3];
  assign LANE_A_DEEMPH_CODE_O = bank[8*`IDX_DEEMPH_AB_HI +: 6];
  assign LANE_B_DEEMPH_CODE_O = {bank[8*`IDX_DEEMPH_AB_HI + 6 +: 2],
                                 bank[8*`IDX_DEEMPH_B_LO +: 4]};
  assign LANE_C_DEEMPH_CODE_O = bank[8*`IDX_DEEMPH_CD_HI +: 6];
  assign LANE_D_DEEMPH_CODE_O = {bank[8*`IDX_DEEMPH_CD_HI + 6 +: 2],
                                 bank[8*`IDX_DEEMPH_D_LO +: 4]};
  assign SYSREF_BUFFER_OFF_O = bank[8*`IDX_SYSREF_BUFFER + `BIT_SYSREF_BUFFER_OFF];
  assign CHAN_A_OFF_O = bank[8*`IDX_CHANNEL_POWER + `BIT_CHAN_A_OFF];
  assign CHAN_B_OFF_O = bank[8*`IDX_CHANNEL_POWER + `BIT_CHAN_B_OFF];
  assign CHAN_C_OFF_O = bank[8*`IDX_CHANNEL_POWER + `BIT_CHAN_C_OFF];
  assign CHAN_D_OFF_O = bank[8*`IDX_CHANNEL_POWER + `BIT_CHAN_D_OFF];
  assign SYNC_AB_BUFFER_OFF_O = bank[8*`IDX_GLOBAL_POWER + `BIT_SYNC_AB_OFF];
  assign SYNC_CD_BUFFER_OFF_O = bank[8*`IDX_SYNC_CD_BUFFER + `BIT_SYNC_CD_OFF];

  always @(posedge CLK_I) begin
    if (RST_I) begin
      sysref_sync <= 2'h0;
      sleep_sync <= 2'h0;
    end else begin
      sysref_sync <= {sysref_sync[0], SYSREF_I};
      sleep_sync <= {sleep_sync[0], SLEEP_PIN_I};
    end
  end

  always @(posedge CLK_I) begin
    if (RST_I) begin
      SYSREF_O <= 1'b0;
      GLOBAL_SLEEP_O <= 1'b0;
      QUICK_SLEEP_O <= 1'b0;
      TRIM_LOAD_O <= 1'b0;
      PAIR_AB_MODE_VALID_O <= 1'b1;
      PAIR_CD_MODE_VALID_O <= 1'b1;
      OUTPUT_SWING_MV_O <= 10'h35C;
      DEEMPH_LEGAL_O <= 4'hF;
    end else begin
      // masking happens after the synchroniser, so a masked edge never leaks
      SYSREF_O <= sysref_sync[1] & ~bank[8*`IDX_SYSREF_MASK + `BIT_SYSREF_MASK];
      GLOBAL_SLEEP_O <= bank[8*`IDX_GLOBAL_POWER + `BIT_GLOBAL_SLEEP] |
                        (sleep_sync[1] &
                         bank[8*`IDX_POWER_PIN_MODE + `BIT_SLEEP_PIN_MODE]);
      QUICK_SLEEP_O <= bank[8*`IDX_POWER_PIN_MODE + `BIT_QUICK_SLEEP] |
                       (sleep_sync[1] &
                        ~bank[8*`IDX_POWER_PIN_MODE + `BIT_SLEEP_PIN_MODE]);
      // one pulse per accepted write of a one while trim load is enabled; the stored bit stays readable
      TRIM_LOAD_O <= wr && hit && page_open && idx == `IDX_TRIM_LOAD_CMD &&
                     wdata[`BIT_TRIM_LOAD_CMD] && TRIM_LOAD_ENABLE_O;
      PAIR_AB_MODE_VALID_O <= mode_defined(PAIR_AB_DOWNCONV_SEL_O);
      PAIR_CD_MODE_VALID_O <= mode_defined(PAIR_CD_DOWNCONV_SEL_O);
      OUTPUT_SWING_MV_O <= swing_mv(OUTPUT_SWING_CODE_O);
      DEEMPH_LEGAL_O <= {deemph_defined(LANE_D_DEEMPH_CODE_O),
                         deemph_defined(LANE_C_DEEMPH_CODE_O),
                         deemph_defined(LANE_B_DEEMPH_CODE_O),
                         deemph_defined(LANE_A_DEEMPH_CODE_O)};
    end
  end

endmodule

/* File: hdl/converter_cfg_pages_regs.vh */
// constants for the converter configuration page register bank
`ifndef CONVERTER_CFG_PAGES_REGS_VH
`define CONVERTER_CFG_PAGES_REGS_VH

// serial frame: read flag, 15 address bits, 8 data bits, msb first
`define CFG_ADDR_W 15
`define CFG_HEADER_BITS 5'h10
`define CFG_FRAME_BITS 5'h18
`define CFG_RESET_VALUE 8'h00
`define CFG_REG_COUNT 19

// register offsets
`define OFS_DIGITAL_PAGE 15'h0012
`define OFS_ANALOG_PAGE 15'h0013
`define OFS_TRIM_RATE 15'h0064
`define OFS_TRIM_LOAD_ENABLE 15'h008C
`define OFS_PAIR_CD_INTERLEAVE 15'h00AC
`define OFS_PAIR_AB_DDC 15'h00AD
`define OFS_PAIR_CD_DDC 15'h00AE
`define OFS_TRIM_LOAD_CMD 15'h00B7
`define OFS_SYSREF_MASK 15'h006A
`define OFS_OUTPUT_SWING 15'h006F
`define OFS_DEEMPH_AB_HI 15'h0071
`define OFS_DEEMPH_B_LO 15'h0072
`define OFS_DEEMPH_CD_HI 15'h0093
`define OFS_DEEMPH_D_LO 15'h0094
`define OFS_SYSREF_BUFFER 15'h009B
`define OFS_CHANNEL_POWER 15'h009D
`define OFS_GLOBAL_POWER 15'h009E
`define OFS_POWER_PIN_MODE 15'h009F
`define OFS_SYNC_CD_BUFFER 15'h00AF

// storage indices
`define IDX_DIGITAL_PAGE 5'h00
`define IDX_ANALOG_PAGE 5'h01
`define IDX_TRIM_RATE 5'h02
`define IDX_TRIM_LOAD_ENABLE 5'h03
`define IDX_PAIR_CD_INTERLEAVE 5'h04
`define IDX_PAIR_AB_DDC 5'h05
`define IDX_PAIR_CD_DDC 5'h06
`define IDX_TRIM_LOAD_CMD 5'h07
`define IDX_SYSREF_MASK 5'h08
`define IDX_OUTPUT_SWING 5'h09
`define IDX_DEEMPH_AB_HI 5'h0A
`define IDX_DEEMPH_B_LO 5'h0B
`define IDX_DEEMPH_CD_HI 5'h0C
`define IDX_DEEMPH_D_LO 5'h0D
`define IDX_SYSREF_BUFFER 5'h0E
`define IDX_CHANNEL_POWER 5'h0F
`define IDX_GLOBAL_POWER 5'h10
`define IDX_POWER_PIN_MODE 5'h11
`define IDX_SYNC_CD_BUFFER 5'h12
`define IDX_LAST_DIGITAL 5'h07

// writable bit masks; other positions store and read zero
`define MSK_DIGITAL_PAGE 8'h01
`define MSK_ANALOG_PAGE 8'h01
`define MSK_TRIM_RATE 8'h02
`define MSK_TRIM_LOAD_ENABLE 8'h02
`define MSK_PAIR_CD_INTERLEAVE 8'h03
`define MSK_PAIR_AB_DDC 8'h0F
`define MSK_PAIR_CD_DDC 8'h0F
`define MSK_TRIM_LOAD_CMD 8'h01
`define MSK_SYSREF_MASK 8'h02
`define MSK_OUTPUT_SWING 8'h70
`define MSK_DEEMPH_HI 8'hFF
`define MSK_DEEMPH_LO 8'h0F
`define MSK_SYSREF_BUFFER 8'h10
`define MSK_CHANNEL_POWER 8'hCC
`define MSK_GLOBAL_POWER 8'h11
`define MSK_POWER_PIN_MODE 8'h03
`define MSK_SYNC_CD_BUFFER 8'h02

// field positions
`define BIT_PAGE_SELECT 0
`define BIT_TRIM_RATE 1
`define BIT_TRIM_LOAD_ENABLE 1
`define BIT_CD_AVG_OUTPUT 1
`define BIT_CD_FIXED_ONE 0
`define BIT_TRIM_LOAD_CMD 0
`define BIT_SYSREF_MASK 1
`define BIT_SWING_LSB 4
`define BIT_SYSREF_BUFFER_OFF 4
`define BIT_CHAN_A_OFF 7
`define BIT_CHAN_B_OFF 6
`define BIT_CHAN_D_OFF 3
`define BIT_CHAN_C_OFF 2
`define BIT_SYNC_AB_OFF 4
`define BIT_GLOBAL_SLEEP 0
`define BIT_SLEEP_PIN_MODE 1
`define BIT_QUICK_SLEEP 0
`define BIT_SYNC_CD_OFF 1

`endif

/* File: test/cfg_serial_host.sv */
// serial configuration host model driving 24-bit frames
`timescale 1ns/10ps
module cfg_serial_host (
  input wire logic clk_i,
  input wire logic sdout_i,
  input wire logic sdout_oe_n_i,
  output logic sen_n_o,
  output logic sclk_o,
  output logic sdin_o
);
  // six clocks per half bit leaves margin over the sync and answer delays
  localparam int HALF = 6;
  initial begin
    sen_n_o = 1'b1;
    sclk_o = 1'b0;
    sdin_o = 1'b0;
  end
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [23:0] frame;
    frame = {rd, a, d};
    q = 8'h00;
    @(negedge clk_i);
    sen_n_o = 1'b0;
    for (int b = 23; b >= 0; b--) begin
      sdin_o = frame[b];
      repeat (HALF) @(negedge clk_i);
      // read data is only taken while the device drives it
      if (b < 8) q[b] = (sdout_oe_n_i === 1'b0) ? sdout_i : 1'bx;
      sclk_o = 1'b1;
      repeat (HALF) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    repeat (HALF) @(negedge clk_i);
    sen_n_o = 1'b1;
    sdin_o = ~sdin_o;
    repeat (8) @(negedge clk_i);
  endtask
endmodule

/* File: test/converter_cfg_pages_properties.sv */
// assertion checker for the configuration page register bank
`timescale 1ns/10ps
module converter_cfg_pages_properties (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SEN_N_I,
  input wire logic SYSREF_I,
  input wire logic SYSREF_O,
  input wire logic [3:0] PAIR_AB_DOWNCONV_SEL_O,
  input wire logic [3:0] PAIR_CD_DOWNCONV_SEL_O,
  input wire logic PAIR_AB_MODE_VALID_O,
  input wire logic PAIR_CD_MODE_VALID_O,
  input wire logic TRIM_LOAD_O,
  input wire logic TRIM_LOAD_ENABLE_O,
  input wire logic [2:0] OUTPUT_SWING_CODE_O,
  input wire logic [9:0] OUTPUT_SWING_MV_O,
  input wire logic [5:0] LANE_A_DEEMPH_CODE_O,
  input wire logic [5:0] LANE_B_DEEMPH_CODE_O,
  input wire logic [5:0] LANE_C_DEEMPH_CODE_O,
  input wire logic [5:0] LANE_D_DEEMPH_CODE_O,
  input wire logic [3:0] DEEMPH_LEGAL_O,
  input wire logic DIGITAL_PAGE_SELECT_O,
  input wire logic ANALOG_PAGE_SELECT_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  function automatic logic mode_ok(input logic [3:0] c);
    return (c <= 4'h8) && (c != 4'h5);
  endfunction
  // legal de-emphasis codes are all-ones runs from bit 0
  function automatic logic emph_ok(input logic [5:0] c);
    return (c & (c + 6'h01)) == 6'h00;
  endfunction
  function automatic logic [9:0] mv_of(input logic [2:0] c);
    logic [9:0] t [8];
    t = '{10'h35C, 10'h32A, 10'h302, 10'h2E9, 10'h3C0, 10'h3A2, 10'h389, 10'h370};
    return t[c];
  endfunction
  mode_ab_flag_a: assert property (PAIR_AB_MODE_VALID_O == mode_ok($past(PAIR_AB_DOWNCONV_SEL_O)))
    else $error("a/b mode flag wrong");
  mode_cd_flag_a: assert property (PAIR_CD_MODE_VALID_O == mode_ok($past(PAIR_CD_DOWNCONV_SEL_O)))
    else $error("c/d mode flag wrong");
  swing_level_a: assert property (OUTPUT_SWING_MV_O == mv_of($past(OUTPUT_SWING_CODE_O)))
    else $error("swing level wrong");
  emph_legal_a: assert property (DEEMPH_LEGAL_O == {emph_ok($past(LANE_D_DEEMPH_CODE_O)),
    emph_ok($past(LANE_C_DEEMPH_CODE_O)), emph_ok($past(LANE_B_DEEMPH_CODE_O)),
    emph_ok($past(LANE_A_DEEMPH_CODE_O))})
    else $error("de-emphasis legal flags wrong");
  trim_gate_a: assert property (TRIM_LOAD_O |-> TRIM_LOAD_ENABLE_O && DIGITAL_PAGE_SELECT_O)
    else $error("trim load while disabled");
  trim_single_a: assert property (TRIM_LOAD_O |=> !TRIM_LOAD_O)
    else $error("trim load pulse too long");
  dig_page_gate_a: assert property ($changed(PAIR_AB_DOWNCONV_SEL_O) |-> DIGITAL_PAGE_SELECT_O)
    else $error("digital register changed with page closed");
  ana_page_gate_a: assert property ($changed(OUTPUT_SWING_CODE_O) |-> ANALOG_PAGE_SELECT_O)
    else $error("analog register changed with page closed");
  sysref_source_a: assert property (SYSREF_O |->
    $past(SYSREF_I, 2) || $past(SYSREF_I, 3) || $past(SYSREF_I, 4))
    else $error("sysref out without sysref in");
  idle_hold_a: assert property (SEN_N_I [*8] |->
    $stable(OUTPUT_SWING_CODE_O) && $stable(LANE_B_DEEMPH_CODE_O))
    else $error("register changed outside a frame");
  trim_seen_c: cover property (TRIM_LOAD_O);
  mode_bad_c: cover property (!PAIR_AB_MODE_VALID_O);
  emph_bad_c: cover property (DEEMPH_LEGAL_O != 4'hF);
  sysref_seen_c: cover property (SYSREF_O);
endmodule

bind converter_cfg_pages converter_cfg_pages_properties u_converter_cfg_pages_properties (
  .CLK_I(CLK_I), .RST_I(RST_I), .SEN_N_I(SEN_N_I), .SYSREF_I(SYSREF_I), .SYSREF_O(SYSREF_O),
  .PAIR_AB_DOWNCONV_SEL_O(PAIR_AB_DOWNCONV_SEL_O), .PAIR_CD_DOWNCONV_SEL_O(PAIR_CD_DOWNCONV_SEL_O),
  .PAIR_AB_MODE_VALID_O(PAIR_AB_MODE_VALID_O), .PAIR_CD_MODE_VALID_O(PAIR_CD_MODE_VALID_O),
  .TRIM_LOAD_O(TRIM_LOAD_O), .TRIM_LOAD_ENABLE_O(TRIM_LOAD_ENABLE_O),
  .OUTPUT_SWING_CODE_O(OUTPUT_SWING_CODE_O), .OUTPUT_SWING_MV_O(OUTPUT_SWING_MV_O),
  .LANE_A_DEEMPH_CODE_O(LANE_A_DEEMPH_CODE_O), .LANE_B_DEEMPH_CODE_O(LANE_B_DEEMPH_CODE_O),
  .LANE_C_DEEMPH_CODE_O(LANE_C_DEEMPH_CODE_O), .LANE_D_DEEMPH_CODE_O(LANE_D_DEEMPH_CODE_O),
  .DEEMPH_LEGAL_O(DEEMPH_LEGAL_O), .DIGITAL_PAGE_SELECT_O(DIGITAL_PAGE_SELECT_O),
  .ANALOG_PAGE_SELECT_O(ANALOG_PAGE_SELECT_O)
);

/* File: test/converter_cfg_pages_regs_test.sv */
// self-checking bench for the configuration page register bank
`timescale 1ns/10ps
module converter_cfg_pages_regs_test;
  logic CLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic SYSREF_I = 1'b0;
  logic SLEEP_PIN_I = 1'b0;
  wire sen_n, sclk, sdin, sdout, sdout_oe_n, sysref_o, avg_en, fixed_one, ab_ok, cd_ok;
  wire trim_load, trim_en, trim_rate, sysref_buf, cha, chb, chc, chd, sync_ab, sync_cd;
  wire gsleep, qsleep, dig_pg, ana_pg;
  wire [3:0] ab_sel, cd_sel, legal;
  wire [2:0] swing;
  wire [9:0] mv;
  wire [5:0] la, lb, lc, ld;
  wire [47:0] outs = {avg_en, fixed_one, ab_sel, cd_sel, trim_en, trim_rate, swing, la, lb, lc,
                      ld, sysref_buf, cha, chb, chc, chd, sync_ab, sync_cd, gsleep, qsleep};
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int trims = 0;
  logic [22:0] regs [17] = '{{15'h006A, 8'h02}, {15'h006F, 8'h70}, {15'h0071, 8'hFF},
    {15'h0072, 8'h0F}, {15'h0093, 8'hFF}, {15'h0094, 8'h0F}, {15'h009B, 8'h10},
    {15'h009D, 8'hCC}, {15'h009E, 8'h11}, {15'h009F, 8'h03}, {15'h00AF, 8'h02},
    {15'h0064, 8'h02}, {15'h008C, 8'h02}, {15'h00AC, 8'h03}, {15'h00AD, 8'h0F},
    {15'h00AE, 8'h0F}, {15'h00B7, 8'h01}};
  logic [9:0] mvtab [8] = '{10'h35C, 10'h32A, 10'h302, 10'h2E9, 10'h3C0, 10'h3A2, 10'h389,
    10'h370};
  logic [15:0] okbits = 16'h01DF;

  converter_cfg_pages u_converter_cfg_pages (
    .CLK_I(CLK_I), .RST_I(RST_I), .SEN_N_I(sen_n), .SCLK_I(sclk), .SDIN_I(sdin),
    .SYSREF_I(SYSREF_I), .SLEEP_PIN_I(SLEEP_PIN_I), .SDOUT_O(sdout), .SDOUT_OE_N_O(sdout_oe_n),
    .SYSREF_O(sysref_o), .PAIR_CD_AVG_OUTPUT_EN_O(avg_en), .PAIR_CD_FIXED_ONE_BIT_O(fixed_one),
    .PAIR_AB_DOWNCONV_SEL_O(ab_sel), .PAIR_CD_DOWNCONV_SEL_O(cd_sel),
    .PAIR_AB_MODE_VALID_O(ab_ok), .PAIR_CD_MODE_VALID_O(cd_ok), .TRIM_LOAD_O(trim_load),
    .TRIM_LOAD_ENABLE_O(trim_en), .TRIM_RATE_SELECT_O(trim_rate), .OUTPUT_SWING_CODE_O(swing),
    .OUTPUT_SWING_MV_O(mv), .LANE_A_DEEMPH_CODE_O(la), .LANE_B_DEEMPH_CODE_O(lb),
    .LANE_C_DEEMPH_CODE_O(lc), .LANE_D_DEEMPH_CODE_O(ld), .DEEMPH_LEGAL_O(legal),
    .SYSREF_BUFFER_OFF_O(sysref_buf), .CHAN_A_OFF_O(cha), .CHAN_B_OFF_O(chb),
    .CHAN_C_OFF_O(chc), .CHAN_D_OFF_O(chd), .SYNC_AB_BUFFER_OFF_O(sync_ab),
    .SYNC_CD_BUFFER_OFF_O(sync_cd), .GLOBAL_SLEEP_O(gsleep), .QUICK_SLEEP_O(qsleep),
    .DIGITAL_PAGE_SELECT_O(dig_pg), .ANALOG_PAGE_SELECT_O(ana_pg)
  );
  cfg_serial_host u_cfg_serial_host (
    .clk_i(CLK_I), .sdout_i(sdout), .sdout_oe_n_i(sdout_oe_n), .sen_n_o(sen_n),
    .sclk_o(sclk), .sdin_o(sdin)
  );

  always #20 CLK_I = ~CLK_I;
  always @(posedge CLK_I) begin
    cycles++;
    if (trim_load === 1'b1) trims++;
  end
  initial begin
    wait (cycles == 80000);
    errors++;
    $display("BAD %0t run did not finish", $time);
    conclude();
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_cfg_serial_host.xfer(1'b0, a, d, q);
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] exp);
    logic [7:0] q;
    u_cfg_serial_host.xfer(1'b1, a, 8'h00, q);
    chk(48'(q), 48'(exp), "read");
  endtask

  initial begin
    repeat (6) @(negedge CLK_I);
    RST_I = 1'b0;
    repeat (4) @(negedge CLK_I);
    wr(15'h006F, 8'h70); // ignored while page closed
    wr(15'h00AD, 8'h03); // ignored while page closed
    chk(outs, 48'h0, "closed pages");
    wr(15'h0012, 8'hFF); // reserved bits set on purpose
    wr(15'h0013, 8'hFF);
    rd(15'h0012, 8'h01);
    rd(15'h0013, 8'h01);
    foreach (regs[i]) rd(regs[i][22:8], 8'h00);
    rd(15'h0055, 8'h00); // unmapped place
    $display("reset test done");
    foreach (regs[i]) wr(regs[i][22:8], 8'hFF); // c/d averaging enable set with interleave
    foreach (regs[i]) rd(regs[i][22:8], regs[i][7:0]);
    chk(outs, {48{1'b1}}, "all set");
    foreach (regs[i]) wr(regs[i][22:8], 8'h00);
    chk(outs, 48'h0, "all clear");
    $display("readback test done");
    chk(48'(trims), 48'h1, "trim count");
    wr(15'h00B7, 8'h01); // trim enable low
    chk(48'(trims), 48'h1, "trim disabled");
    wr(15'h008C, 8'h02);
    wr(15'h00B7, 8'h01);
    chk(48'(trims), 48'h2, "trim enabled");
    $display("trim test done");
    for (int c = 0; c < 8; c++) begin
      wr(15'h006F, {1'b0, c[2:0], 4'h0});
      chk(48'({swing, mv}), 48'({c[2:0], mvtab[c]}), "swing");
    end
    $display("swing test done");
    for (int c = 0; c < 16; c++) begin
      wr(15'h00AD, 8'(c)); // undefined codes included
      wr(15'h00AE, 8'(15 - c));
      chk(48'({ab_sel, cd_sel, ab_ok, cd_ok}), 48'({c[3:0], 4'(15 - c), okbits[c],
          okbits[15 - c]}), "ddc");
    end
    $display("ddc test done");
    wr(15'h0071, 8'h83); // lane b made illegal on purpose
    wr(15'h0072, 8'h05);
    wr(15'h0093, 8'hDF);
    wr(15'h0094, 8'h0F);
    chk(48'({la, lb, lc, ld, legal}), 48'({6'h03, 6'h25, 6'h1F, 6'h3F, 4'hD}), "deemph");
    $display("deemph test done");
    SLEEP_PIN_I = 1'b1;
    wr(15'h009F, 8'h00);
    chk(48'({gsleep, qsleep}), 48'h1, "pin fast");
    wr(15'h009F, 8'h02);
    chk(48'({gsleep, qsleep}), 48'h2, "pin global");
    SLEEP_PIN_I = 1'b0;
    $display("sleep test done");
    SYSREF_I = 1'b1;
    wr(15'h006A, 8'h00);
    chk(48'(sysref_o), 48'h1, "sysref pass");
    wr(15'h006A, 8'h02);
    chk(48'(sysref_o), 48'h0, "sysref masked");
    $display("sysref test done");
    conclude();
  end
endmodule
